/* File: rtl/rcs_pkg.sv */
// package of the channel status object bank: object addresses, field layouts, defaults
// assumes one system clock; objects are reached by index and subindex as documented
package rcs_pkg;
    // ----------------------------------------------------------------
    // geometry
    // ----------------------------------------------------------------
    localparam int RCS_CHANNELS = 4;
    localparam logic [15:0] RCS_INDEX_SPACING = 16'h0010;
    localparam logic [15:0] RCS_CHANNEL_COUNT = 16'h0004;
    // profile number of each channel entry, value arbitrary
    localparam logic [31:0] RCS_CHANNEL_PROFILE = 32'h0000_5a01;
    // ----------------------------------------------------------------
    // object indices (channel n adds n * spacing to the inputs, internal and factory objects)
    // ----------------------------------------------------------------
    localparam logic [15:0] RCS_IDX_INPUTS = 16'h6000;
    localparam logic [15:0] RCS_IDX_INTERNAL = 16'h800e;
    localparam logic [15:0] RCS_IDX_FACTORY = 16'h800f;
    localparam logic [15:0] RCS_IDX_PROFILE = 16'hf000;
    localparam logic [15:0] RCS_IDX_CODE_WORD = 16'hf008;
    localparam logic [15:0] RCS_IDX_MODULE_LIST = 16'hf010;
    // ----------------------------------------------------------------
    // subindices
    // ----------------------------------------------------------------
    localparam logic [7:0] RCS_SUB_COUNT = 8'h00;
    localparam logic [7:0] RCS_SUB_UNDER = 8'h01;
    localparam logic [7:0] RCS_SUB_OVER = 8'h02;
    localparam logic [7:0] RCS_SUB_LIMIT1 = 8'h03;
    localparam logic [7:0] RCS_SUB_LIMIT2 = 8'h05;
    localparam logic [7:0] RCS_SUB_ERROR = 8'h07;
    localparam logic [7:0] RCS_SUB_STATE = 8'h0f;
    localparam logic [7:0] RCS_SUB_TOGGLE = 8'h10;
    localparam logic [7:0] RCS_SUB_VALUE = 8'h11;
    localparam logic [7:0] RCS_SUB_RAW_SENSOR = 8'h01;
    localparam logic [7:0] RCS_SUB_RES_SENSOR = 8'h02;
    localparam logic [7:0] RCS_SUB_RAW_LINE = 8'h03;
    localparam logic [7:0] RCS_SUB_RES_LINE = 8'h04;
    localparam logic [7:0] RCS_SUB_SPACING = 8'h01;
    localparam logic [7:0] RCS_SUB_MODCOUNT = 8'h02;
    localparam logic [7:0] RCS_SUB_CODE = 8'h00;
    // ----------------------------------------------------------------
    // subindex counts
    // ----------------------------------------------------------------
    localparam logic [7:0] RCS_INPUTS_MAXSUB = 8'h11;
    localparam logic [7:0] RCS_INTERNAL_MAXSUB = 8'h04;
    localparam logic [7:0] RCS_FACTORY_MAXSUB_OLD = 8'h06;
    localparam logic [7:0] RCS_FACTORY_MAXSUB_TEN = 8'h08;
    localparam logic [7:0] RCS_PROFILE_MAXSUB = 8'h02;
    localparam logic [7:0] RCS_MODULE_LIST_MAXSUB = 8'h04;
    localparam int RCS_FACTORY_WORDS = 8;
    localparam int RCS_FACTORY_WORDS_OLD = 6;
    // ----------------------------------------------------------------
    // defaults and codes
    // ----------------------------------------------------------------
    localparam logic [15:0] RCS_GAIN_DEFAULT = 16'h9e50;
    localparam logic [15:0] RCS_OFFSET_DEFAULT = 16'h0000;
    localparam logic [1:0] RCS_LIM_OFF = 2'h0;
    localparam logic [1:0] RCS_LIM_ABOVE = 2'h1;
    localparam logic [1:0] RCS_LIM_BELOW = 2'h2;
    localparam logic [1:0] RCS_LIM_EQUAL = 2'h3;

    // one sample delivered by the measurement path for one channel
    typedef struct packed {
        logic [1:0] channel;
        logic under;
        logic over;
        logic valid;
        logic lim1_on;
        logic lim2_on;
        logic signed [15:0] limit1;
        logic signed [15:0] limit2;
        logic signed [15:0] value;
        logic signed [31:0] raw_sensor;
        logic [15:0] res_sensor;
        logic signed [31:0] raw_line;
        logic [15:0] res_line;
    } rcs_sample_t;

    // process data of one channel
    typedef struct packed {
        logic under;
        logic over;
        logic [1:0] limit1;
        logic [1:0] limit2;
        logic error;
        logic state;
        logic toggle;
        logic signed [15:0] value;
    } rcs_pdo_t;

    // internal measurement entries of one channel
    typedef struct packed {
        logic signed [31:0] raw_sensor;
        logic [15:0] res_sensor;
        logic signed [31:0] raw_line;
        logic [15:0] res_line;
    } rcs_internal_t;

    // object access request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] index;
        logic [7:0] sub;
        logic [31:0] wdata;
    } rcs_req_t;

    // object access answer
    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] rdata;
    } rcs_rsp_t;
endpackage : rcs_pkg

/* File: rtl/rcs_channel_objects.sv */
// channel status object bank of a four-channel resistance thermometer input
// assumes samples and object requests come from logic on clock_in
`timescale 1ns/1ps
`default_nettype none
module rcs_channel_objects #(
    parameter bit FIRMWARE_TEN = 1'b1
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // measurement path
    input wire logic sample_valid_in,
    input var rcs_pkg::rcs_sample_t sample_in,
    // object access
    input var rcs_pkg::rcs_req_t req_in,
    output var rcs_pkg::rcs_rsp_t rsp_out,
    // process data of all channels
    output var rcs_pkg::rcs_pdo_t [rcs_pkg::RCS_CHANNELS-1:0] pdo_out
);
    import rcs_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        rcs_pdo_t [RCS_CHANNELS-1:0] pdo;
        rcs_internal_t [RCS_CHANNELS-1:0] internal;
        logic [RCS_CHANNELS-1:0][RCS_FACTORY_WORDS-1:0][15:0] factory;
        rcs_rsp_t rsp;
    } rcs_state_t;

    rcs_state_t state_q;
    rcs_state_t state_d;

    // limit comparison
    function automatic logic [1:0] rcs_limit(input logic on, input logic signed [15:0] v,
                                             input logic signed [15:0] lim);
        logic [1:0] code;
        code = RCS_LIM_OFF;
        if (on) begin
            if (v > lim) begin
                code = RCS_LIM_ABOVE;
            end else if (v < lim) begin
                code = RCS_LIM_BELOW;
            end else begin
                code = RCS_LIM_EQUAL;
            end
        end
        return code;
    endfunction : rcs_limit

    // reset image
    function automatic rcs_state_t rcs_reset_image();
        rcs_state_t s;
        s = '0;
        for (int c = 0; c < RCS_CHANNELS; c++) begin
            for (int w = 0; w < RCS_FACTORY_WORDS; w++) begin
                s.factory[c][w] = w[0] ? RCS_GAIN_DEFAULT : RCS_OFFSET_DEFAULT;
            end
        end
        return s;
    endfunction : rcs_reset_image

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    logic [15:0] idx_base;
    logic [1:0] idx_chan;
    logic chan_ok;
    logic [7:0] factory_maxsub;
    logic [7:0] req_sub_minus1;
    logic [2:0] factory_word;

    always_comb begin
        idx_base = {req_in.index[15:8], 4'h0, req_in.index[3:0]};
        idx_chan = req_in.index[5:4];
        chan_ok = (req_in.index[7:6] == 2'b00);
        factory_maxsub = FIRMWARE_TEN ? RCS_FACTORY_MAXSUB_TEN : RCS_FACTORY_MAXSUB_OLD;
        req_sub_minus1 = req_in.sub - 8'h01;
        factory_word = req_sub_minus1[2:0];
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        rcs_pdo_t p;
        rcs_internal_t it;
        logic hit;
        logic [31:0] rd;
        p = '0;
        it = '0;
        hit = 1'b0;
        rd = '0;
        state_d = state_q;

        // one channel updates as a whole
        if (sample_valid_in) begin
            p = state_q.pdo[sample_in.channel];
            p.under = sample_in.under;
            p.over = sample_in.over;
            p.limit1 = rcs_limit(sample_in.lim1_on, sample_in.value, sample_in.limit1);
            p.limit2 = rcs_limit(sample_in.lim2_on, sample_in.value, sample_in.limit2);
            p.error = ~sample_in.valid;
            p.state = ~sample_in.valid;
            p.toggle = ~state_q.pdo[sample_in.channel].toggle;
            p.value = sample_in.value;
            state_d.pdo[sample_in.channel] = p;
            it.raw_sensor = sample_in.raw_sensor;
            it.res_sensor = sample_in.res_sensor;
            it.raw_line = sample_in.raw_line;
            it.res_line = sample_in.res_line;
            state_d.internal[sample_in.channel] = it;
        end

        // object reads and writes
        p = state_q.pdo[idx_chan];
        it = state_q.internal[idx_chan];
        if (chan_ok && idx_base == RCS_IDX_INPUTS) begin
            hit = 1'b1;
            case (req_in.sub)
                RCS_SUB_COUNT: rd = {24'h00_0000, RCS_INPUTS_MAXSUB};
                RCS_SUB_UNDER: rd = {31'h0000_0000, p.under};
                RCS_SUB_OVER: rd = {31'h0000_0000, p.over};
                RCS_SUB_LIMIT1: rd = {30'h0000_0000, p.limit1};
                RCS_SUB_LIMIT2: rd = {30'h0000_0000, p.limit2};
                RCS_SUB_ERROR: rd = {31'h0000_0000, p.error};
                RCS_SUB_STATE: rd = {31'h0000_0000, p.state};
                RCS_SUB_TOGGLE: rd = {31'h0000_0000, p.toggle};
                RCS_SUB_VALUE: rd = {{16{p.value[15]}}, p.value};
                default: hit = 1'b0;
            endcase
        end else if (chan_ok && idx_base == RCS_IDX_INTERNAL) begin
            hit = 1'b1;
            case (req_in.sub)
                RCS_SUB_COUNT: rd = {24'h00_0000, RCS_INTERNAL_MAXSUB};
                RCS_SUB_RAW_SENSOR: rd = it.raw_sensor;
                RCS_SUB_RES_SENSOR: rd = {16'h0000, it.res_sensor};
                RCS_SUB_RAW_LINE: rd = it.raw_line;
                RCS_SUB_RES_LINE: rd = {16'h0000, it.res_line};
                default: hit = 1'b0;
            endcase
        end else if (chan_ok && idx_base == RCS_IDX_FACTORY) begin
            if (req_in.sub == RCS_SUB_COUNT) begin
                hit = 1'b1;
                rd = {24'h00_0000, factory_maxsub};
            end else if (req_in.sub <= factory_maxsub) begin
                hit = 1'b1;
                rd = {16'h0000, state_q.factory[idx_chan][factory_word]};
                if (factory_word[0] == 1'b0) begin
                    rd = {{16{rd[15]}}, rd[15:0]};
                end
                if (req_in.wr) begin
                    state_d.factory[idx_chan][factory_word] = req_in.wdata[15:0];
                end
            end
        end else if (req_in.index == RCS_IDX_PROFILE) begin
            hit = 1'b1;
            case (req_in.sub)
                RCS_SUB_COUNT: rd = {24'h00_0000, RCS_PROFILE_MAXSUB};
                RCS_SUB_SPACING: rd = {16'h0000, RCS_INDEX_SPACING};
                RCS_SUB_MODCOUNT: rd = {16'h0000, RCS_CHANNEL_COUNT};
                default: hit = 1'b0;
            endcase
        end else if (req_in.index == RCS_IDX_CODE_WORD) begin
            hit = (req_in.sub == RCS_SUB_CODE);
            rd = '0;
        end else if (req_in.index == RCS_IDX_MODULE_LIST) begin
            if (req_in.sub == RCS_SUB_COUNT) begin
                hit = 1'b1;
                rd = {24'h00_0000, RCS_MODULE_LIST_MAXSUB};
            end else if (req_in.sub <= RCS_MODULE_LIST_MAXSUB) begin
                hit = 1'b1;
                rd = RCS_CHANNEL_PROFILE;
            end
        end

        // writes to read-only objects are refused
        if (hit && req_in.wr && !(chan_ok && idx_base == RCS_IDX_FACTORY)
            && req_in.index != RCS_IDX_CODE_WORD) begin
            hit = 1'b0;
        end
        state_d.rsp.ack = req_in.rd | req_in.wr;
        state_d.rsp.err = (req_in.rd | req_in.wr) & ~hit;
        state_d.rsp.rdata = (req_in.rd & hit) ? rd : 32'h0000_0000;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= rcs_reset_image();
        end else begin
            state_q <= state_d;
        end
    end

    assign rsp_out = state_q.rsp;
    assign pdo_out = state_q.pdo;
endmodule : rcs_channel_objects
`default_nettype wire

/* File: tb/rcs_channel_objects_props.sv */
// checker of the channel status object bank
// assumes bind to rcs_channel_objects, one clock domain
`timescale 1ns/1ps
`default_nettype none
module rcs_channel_objects_props #(
    parameter bit FIRMWARE_TEN = 1'b1
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // watched ports
    input wire logic sample_valid_in,
    input var rcs_pkg::rcs_sample_t sample_in,
    input var rcs_pkg::rcs_req_t req_in,
    input var rcs_pkg::rcs_rsp_t rsp_out,
    input var rcs_pkg::rcs_pdo_t [rcs_pkg::RCS_CHANNELS-1:0] pdo_out
);
    import rcs_pkg::*;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    rcs_sample_t smp_q;
    rcs_pdo_t old_q;
    rcs_pdo_t now_p;
    always_ff @(posedge clock_in) begin
        smp_q <= sample_in;
        old_q <= pdo_out[sample_in.channel];
    end
    assign now_p = pdo_out[smp_q.channel];
    function automatic logic [1:0] lc(logic on, logic signed [15:0] v, logic signed [15:0] l);
        return !on ? RCS_LIM_OFF : v > l ? RCS_LIM_ABOVE : v < l ? RCS_LIM_BELOW : RCS_LIM_EQUAL;
    endfunction : lc
    sequence s_smp;
        sample_valid_in;
    endsequence
    sequence s_fac_kilo;
        req_in.rd && req_in.index == RCS_IDX_FACTORY && req_in.sub inside {8'h07, 8'h08};
    endsequence
    chk_under_flag: assert property (s_smp |=> now_p.under == smp_q.under)
        else $error("underrange flag wrong");
    chk_over_flag: assert property (s_smp |=> now_p.over == smp_q.over)
        else $error("overrange flag wrong");
    chk_limit_code: assert property (s_smp |=>
        now_p.limit1 == lc(smp_q.lim1_on, smp_q.value, smp_q.limit1) &&
        now_p.limit2 == lc(smp_q.lim2_on, smp_q.value, smp_q.limit2)) else $error("limit code wrong");
    chk_error_flag: assert property (s_smp |=> now_p.error == !smp_q.valid)
        else $error("error flag wrong");
    chk_state_bit: assert property (s_smp |=> now_p.state == !smp_q.valid)
        else $error("state bit wrong");
    chk_toggle_flip: assert property (s_smp |=> now_p.toggle != old_q.toggle)
        else $error("toggle not inverted");
    chk_value_copy: assert property (s_smp |=> now_p.value == smp_q.value)
        else $error("value not copied");
    chk_hold_idle: assert property (!sample_valid_in |=> $stable(pdo_out))
        else $error("process data moved without sample");
    chk_ro_refused: assert property (req_in.wr && req_in.index == RCS_IDX_PROFILE |=>
        rsp_out.ack && rsp_out.err) else $error("profile write not refused");
    chk_count_read: assert property (req_in.rd && req_in.index == RCS_IDX_PROFILE &&
        req_in.sub == RCS_SUB_MODCOUNT |=> rsp_out.rdata == {16'h0000, RCS_CHANNEL_COUNT})
        else $error("channel count wrong");
    chk_kilo_pair: assert property (s_fac_kilo |=> rsp_out.err == !FIRMWARE_TEN)
        else $error("kilo-ohm pair presence wrong");
    chk_ack_next: assert property (rsp_out.ack == $past(req_in.rd || req_in.wr))
        else $error("ack not one cycle after request");
endmodule : rcs_channel_objects_props
bind rcs_channel_objects rcs_channel_objects_props #(.FIRMWARE_TEN(FIRMWARE_TEN)) props_i (
    .clock_in(clock_in), .rst_in(rst_in), .sample_valid_in(sample_valid_in),
    .sample_in(sample_in), .req_in(req_in), .rsp_out(rsp_out), .pdo_out(pdo_out));
`default_nettype wire

/* File: tb/rcs_master_model.sv */
// fieldbus master model: issues object requests, takes the answers
// assumes access is called at a falling edge of clock_in
`timescale 1ns/1ps
`default_nettype none
module rcs_master_model (
    // clock
    input wire logic clock_in,
    // object access
    output var rcs_pkg::rcs_req_t req_out,
    input var rcs_pkg::rcs_rsp_t rsp_in
);
    import rcs_pkg::*;
    // vendor calibration flag, set but not read by any task
    logic vendor_cal_en = 1'b1;
    initial req_out = '0;
    task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
        input logic [31:0] wd, output rcs_rsp_t rsp);
        req_out = '{rd: !wr, wr: wr, index: idx, sub: sub, wdata: wd};
        @(negedge clock_in);
        rsp = rsp_in;
    endtask : access
    task automatic idle();
        req_out = '0;
    endtask : idle
endmodule : rcs_master_model
`default_nettype wire

/* File: tb/rcs_channel_objects_tb.sv */
// self-checking bench of the channel status object bank
// assumes the master model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end
module rcs_channel_objects_tb;
    import rcs_pkg::*;
    localparam logic [31:0] GAIN_W = {16'h0000, RCS_GAIN_DEFAULT};
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic sample_valid_in = 1'b0;
    rcs_sample_t sample_in = '0;
    rcs_sample_t s;
    rcs_sample_t ls;
    rcs_req_t req_in;
    rcs_rsp_t rsp_out;
    rcs_rsp_t rsp;
    rcs_pdo_t [RCS_CHANNELS-1:0] pdo_out;
    rcs_pdo_t pexp;
    logic [1:0] pch;
    logic [3:0] tog = '0;
    logic [159:0] rnd;
    int err_total = 0;
    int n_tests = 0;
    int seed = 38;
    always #25 clock_in = ~clock_in;
    rcs_channel_objects rcs_channel_objects_i (.clock_in(clock_in), .rst_in(rst_in),
        .sample_valid_in(sample_valid_in), .sample_in(sample_in), .req_in(req_in),
        .rsp_out(rsp_out), .pdo_out(pdo_out));
    rcs_master_model rcs_master_model_i (.clock_in(clock_in), .req_out(req_in),
        .rsp_in(rsp_out));
    function automatic logic [1:0] lim(logic on, logic signed [15:0] v, logic signed [15:0] l);
        return !on ? 2'h0 : v > l ? 2'h1 : v < l ? 2'h2 : 2'h3;
    endfunction : lim
    function automatic rcs_pdo_t exp_pdo(rcs_sample_t x, logic t);
        return '{under: x.under, over: x.over, limit1: lim(x.lim1_on, x.value, x.limit1),
            limit2: lim(x.lim2_on, x.value, x.limit2), error: !x.valid, state: !x.valid,
            toggle: t, value: x.value};
    endfunction : exp_pdo
    function automatic logic [15:0] ob(logic [15:0] base, int ch);
        return base + RCS_INDEX_SPACING * 16'(ch);
    endfunction : ob
    task automatic io(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
        input logic [31:0] wd, input logic err, input logic [31:0] exp);
        rcs_master_model_i.access(wr, idx, sub, wd, rsp);
        `CHK(rsp.ack, 1'b1)
        `CHK(rsp.err, err)
        if (!wr || err) `CHK(rsp.rdata, exp)
    endtask : io
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_sim
    task automatic do_reset();
        rst_in = 1'b1;
        tog = '0;
        repeat (3) @(negedge clock_in);
        rst_in = 1'b0;
        for (int c = 0; c < RCS_CHANNELS; c++) begin
            `CHK(pdo_out[c], rcs_pdo_t'(0))
            for (int k = 1; k <= 8; k++) begin
                io(0, ob(RCS_IDX_FACTORY, c), 8'(k), 0, 0, k[0] ? 0 : GAIN_W);
            end
            for (int k = 1; k <= 4; k++) begin
                io(0, ob(RCS_IDX_INTERNAL, c), 8'(k), 0, 0, 0);
            end
        end
    endtask : do_reset
    initial begin
        #2000000;
        err_total++;
        end_sim();
    end
    initial begin
        do_reset();
        io(0, RCS_IDX_PROFILE, RCS_SUB_SPACING, 0, 0, 32'h0000_0010);
        io(0, RCS_IDX_PROFILE, RCS_SUB_MODCOUNT, 0, 0, 32'h0000_0004);
        io(1, RCS_IDX_PROFILE, RCS_SUB_MODCOUNT, 32'h0000_0008, 1, 0);
        io(0, RCS_IDX_FACTORY, 8'h09, 0, 1, 0);
        io(1, ob(RCS_IDX_INTERNAL, 1), RCS_SUB_RAW_LINE, 32'h0000_1234, 1, 0);
        io(1, ob(RCS_IDX_FACTORY, 3), 8'h01, 32'h0000_8001, 0, 0);
        io(0, ob(RCS_IDX_FACTORY, 3), 8'h01, 0, 0, 32'hffff_8001);
        io(1, RCS_IDX_FACTORY, 8'h08, 32'h0000_c001, 0, 0);
        io(0, RCS_IDX_FACTORY, 8'h08, 0, 0, 32'h0000_c001);
        io(0, 16'h7000, 8'h00, 0, 1, 0);
        io(0, ob(RCS_IDX_INPUTS, 2), RCS_SUB_COUNT, 0, 0, 32'h0000_0011);
        io(0, ob(RCS_IDX_FACTORY, 1), RCS_SUB_COUNT, 0, 0, 32'h0000_0008);
        io(0, ob(RCS_IDX_INTERNAL, 2), RCS_SUB_COUNT, 0, 0, 32'h0000_0004);
        io(0, RCS_IDX_PROFILE, RCS_SUB_COUNT, 0, 0, 32'h0000_0002);
        io(0, RCS_IDX_MODULE_LIST, RCS_SUB_COUNT, 0, 0, 32'h0000_0004);
        io(0, RCS_IDX_MODULE_LIST, 8'h02, 0, 0, RCS_CHANNEL_PROFILE);
        io(0, RCS_IDX_MODULE_LIST, 8'h05, 0, 1, 0);
        io(1, RCS_IDX_CODE_WORD, RCS_SUB_CODE, 32'h1234_5678, 0, 0);
        io(0, RCS_IDX_CODE_WORD, RCS_SUB_CODE, 0, 0, 0);
        rcs_master_model_i.idle();
        for (int i = 0; i <= 200; i++) begin
            if (i > 0) `CHK(pdo_out[pch], pexp)
            rnd = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
            s = rnd[$bits(rcs_sample_t)-1:0];
            if (i % 4 == 0) s.limit2 = s.value;
            sample_valid_in = (i < 200) && (i % 7 != 6);
            sample_in = s;
            if (sample_valid_in) begin
                tog[s.channel] = ~tog[s.channel];
                pch = s.channel;
                pexp = exp_pdo(s, tog[s.channel]);
                ls = s;
            end
            @(negedge clock_in);
        end
        io(0, ob(RCS_IDX_INPUTS, pch), RCS_SUB_VALUE, 0, 0, {{16{ls.value[15]}}, ls.value});
        io(0, ob(RCS_IDX_INPUTS, pch), RCS_SUB_TOGGLE, 0, 0, {31'h0, tog[pch]});
        io(0, ob(RCS_IDX_INTERNAL, pch), RCS_SUB_RAW_SENSOR, 0, 0, ls.raw_sensor);
        io(0, ob(RCS_IDX_INTERNAL, pch), RCS_SUB_RES_SENSOR, 0, 0, {16'h0, ls.res_sensor});
        io(0, ob(RCS_IDX_INTERNAL, pch), RCS_SUB_RES_LINE, 0, 0, {16'h0, ls.res_line});
        rcs_master_model_i.idle();
        do_reset();
        end_sim();
    end
endmodule : rcs_channel_objects_tb
`default_nettype wire
